// file: hdl/pulse_timer_irq.v
// interrupt status, enable and pulse-width timers for three counters
`default_nettype none
`include "pulse_timer_irq_consts.vh"

// Functional notes
// RULE1 - status: bit5 timer ovf, bit4 counter ovf, bits3-1 match, bit0 interval
// RULE2 - reading a status register clears all its flags; flags reset to zero
// RULE3 - status bits 31 to 6 ignore writes and read zero
// RULE4 - per-counter enable register, same layout; one enables a cause
// RULE5 - zero disables a cause; enables reset to zero
// RULE6 - control bit0 starts the pulse timer, zero stops it
// RULE7 - control bit1 one counts clock cycles while the input is low
// RULE8 - control bit1 zero counts clock cycles while the input is high
// RULE9 - control bit2 one lets the count wrap and keep counting
// RULE10 - control bit2 zero disables the timer and zeros count on overflow
// RULE11 - read-only 16-bit measured count per pulse timer, reset zero
// RULE12 - count register bits 31 to 16 read zero
// RULE13 - control register bits 31 to 3 are ignored
// RULE14 - pulse timer overflow sets its counter's status bit 5
// RULE15 - match events from the counters set match status bits
// RULE16 - counter interrupt high while a flag and its enable are both set
// RULE17 - count restarts at each selected level and result holds after
// RULE18 - pulse inputs pass a two flip-flop synchroniser first
module pulse_timer_irq (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdData,
    // counter event strobes, one bit per counter
    input  wire [2:0]  intervalEvt,
    input  wire [2:0]  match1Evt,
    input  wire [2:0]  match2Evt,
    input  wire [2:0]  match3Evt,
    input  wire [2:0]  cntOvfEvt,
    // external pulse inputs, one per pulse timer
    input  wire [2:0]  pulseIn,
    // interrupt outputs, one per counter
    output reg  [2:0]  irqOut
);

    // status, enable and control registers
    reg [`IRQ_WIDTH-1:0]   status_reg  [0:2];
    reg [`IRQ_WIDTH-1:0]   enable_reg  [0:2];
    reg [`CTRL_WIDTH-1:0]  ctrl_reg    [0:2];
    reg [`COUNT_WIDTH-1:0] run_reg     [0:2];
    reg [`COUNT_WIDTH-1:0] result_reg  [0:2];
    reg [2:0]              syncA_reg;
    reg [2:0]              syncB_reg;
    reg [2:0]              active_reg;
    reg [2:0]              ptOvf;
    reg [31:0]             rdData_next;

    // two flip-flop synchroniser; only syncB is read by logic
    always @(posedge clk) begin
        if (!rst_n) begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
        end else begin
            syncA_reg <= pulseIn;   // [RULE18]
            syncB_reg <= syncA_reg; // [RULE18]
        end
    end

    genvar n;
    generate
        for (n = 0; n < 3; n = n + 1) begin : gChan
            wire wrCtrl = regWrite &&
                          regAddr == (`OFS_PT1_CONTROL + 8'h04 * n);
            wire wrEn   = regWrite &&
                          regAddr == (`OFS_CNT1_ENABLE + 8'h04 * n);
            wire rdStat = regRead &&
                          regAddr == (`OFS_CNT1_STATUS + 8'h04 * n);
            // selected level present: low when bit1 set, else high
            wire lvl    = ctrl_reg[n][`BIT_PT_LOW] ?
                          ~syncB_reg[n] : syncB_reg[n]; // [RULE7] [RULE8]
            wire cnting = ctrl_reg[n][`BIT_PT_ENABLE] && lvl; // [RULE6]
            wire atMax  = run_reg[n] == `COUNT_MAX;
            wire [`IRQ_WIDTH-1:0] evts = {ptOvf[n], cntOvfEvt[n],
                match3Evt[n], match2Evt[n], match1Evt[n],
                intervalEvt[n]}; // [RULE1] [RULE15] [RULE14]

            always @* begin
                ptOvf[n] = cnting && atMax;
            end

            // control and enable registers; only low bits are stored
            always @(posedge clk) begin
                if (!rst_n) begin
                    ctrl_reg[n]   <= `RST_CTRL;  // [RULE13]
                    enable_reg[n] <= `RST_IRQ;   // [RULE5]
                end else begin
                    if (wrEn)
                        enable_reg[n] <= regWrData[`IRQ_WIDTH-1:0]; // [RULE4]
                    if (wrCtrl)
                        ctrl_reg[n] <= regWrData[`CTRL_WIDTH-1:0]; // [RULE13]
                    else if (ptOvf[n] && !ctrl_reg[n][`BIT_PT_WRAP])
                        ctrl_reg[n][`BIT_PT_ENABLE] <= 1'b0; // [RULE10]
                end
            end

            // pulse measurement: run counter and held result
            always @(posedge clk) begin
                if (!rst_n) begin
                    run_reg[n]    <= `RST_COUNT;
                    result_reg[n] <= `RST_COUNT; // [RULE11]
                    active_reg[n] <= 1'b0;
                end else begin
                    active_reg[n] <= cnting;
                    if (cnting && !active_reg[n]) begin
                        run_reg[n] <= 16'h0001; // [RULE17]
                    end else if (cnting) begin
                        if (atMax && !ctrl_reg[n][`BIT_PT_WRAP]) begin
                            run_reg[n]    <= `RST_COUNT; // [RULE10]
                            result_reg[n] <= `RST_COUNT; // [RULE10]
                        end else begin
                            run_reg[n] <= run_reg[n] + 16'h0001; // [RULE9]
                        end
                    end else if (active_reg[n]) begin
                        result_reg[n] <= run_reg[n]; // [RULE17]
                    end
                end
            end

            // sticky status: a new event wins over the read clear
            always @(posedge clk) begin
                if (!rst_n)
                    status_reg[n] <= `RST_IRQ; // [RULE2]
                else if (rdStat)
                    status_reg[n] <= evts; // [RULE2]
                else
                    status_reg[n] <= status_reg[n] | evts; // [RULE1]
            end

            // level interrupt from enabled flags
            always @(posedge clk) begin
                if (!rst_n)
                    irqOut[n] <= 1'b0;
                else if (rdStat)
                    irqOut[n] <= |(evts & enable_reg[n]); // [RULE16]
                else
                    irqOut[n] <= |((status_reg[n] | evts) &
                                   enable_reg[n]); // [RULE16]
            end
        end
    endgenerate

    // read decode; unmapped and undefined bits read zero
    always @* begin
        rdData_next = 32'h0000_0000;
        case (regAddr)
            `OFS_CNT1_STATUS: rdData_next[5:0] = status_reg[0]; // [RULE3]
            `OFS_CNT2_STATUS: rdData_next[5:0] = status_reg[1];
            `OFS_CNT3_STATUS: rdData_next[5:0] = status_reg[2];
            `OFS_CNT1_ENABLE: rdData_next[5:0] = enable_reg[0];
            `OFS_CNT2_ENABLE: rdData_next[5:0] = enable_reg[1];
            `OFS_CNT3_ENABLE: rdData_next[5:0] = enable_reg[2];
            `OFS_PT1_CONTROL: rdData_next[2:0] = ctrl_reg[0];
            `OFS_PT2_CONTROL: rdData_next[2:0] = ctrl_reg[1];
            `OFS_PT3_CONTROL: rdData_next[2:0] = ctrl_reg[2];
            `OFS_PT1_COUNT:   rdData_next[15:0] = result_reg[0]; // [RULE12]
            `OFS_PT2_COUNT:   rdData_next[15:0] = result_reg[1];
            `OFS_PT3_COUNT:   rdData_next[15:0] = result_reg[2];
            default:          rdData_next = 32'h0000_0000;
        endcase
    end

    // read data register, valid the cycle after the strobe
    always @(posedge clk) begin
        if (!rst_n)
            regRdData <= 32'h0000_0000;
        else if (regRead)
            regRdData <= rdData_next;
        else
            regRdData <= 32'h0000_0000;
    end

endmodule // pulse_timer_irq
`default_nettype wire

// file: hdl/pulse_timer_irq_consts.vh
// register offsets, field positions and reset values of the timer interrupt block
`ifndef PULSE_TIMER_IRQ_CONSTS_VH
`define PULSE_TIMER_IRQ_CONSTS_VH

// register byte offsets
`define OFS_CNT1_STATUS 8'h54
`define OFS_CNT2_STATUS 8'h58
`define OFS_CNT3_STATUS 8'h5c
`define OFS_CNT1_ENABLE 8'h60
`define OFS_CNT2_ENABLE 8'h64
`define OFS_CNT3_ENABLE 8'h68
`define OFS_PT1_CONTROL 8'h6c
`define OFS_PT2_CONTROL 8'h70
`define OFS_PT3_CONTROL 8'h74
`define OFS_PT1_COUNT   8'h78
`define OFS_PT2_COUNT   8'h7c
`define OFS_PT3_COUNT   8'h80

// status and enable field positions
`define BIT_INTERVAL    0
`define BIT_MATCH1      1
`define BIT_MATCH2      2
`define BIT_MATCH3      3
`define BIT_CNT_OVF     4
`define BIT_PT_OVF      5
`define IRQ_WIDTH       6

// pulse timer control field positions
`define BIT_PT_ENABLE   0
`define BIT_PT_LOW      1
`define BIT_PT_WRAP     2
`define CTRL_WIDTH      3
`define COUNT_WIDTH     16

// reset values and maximum count
`define RST_IRQ         6'h00
`define RST_CTRL        3'h0
`define RST_COUNT       16'h0000
`define COUNT_MAX       16'hffff

`endif

// file: tb/pulse_timer_irq_monitor.sv
// checker on the register port and interrupt outputs
`default_nettype none
`include "pulse_timer_irq_consts.vh"
module pulse_timer_irq_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    // events and interrupts
    input wire logic [2:0]  intervalEvt,
    input wire logic [2:0]  match1Evt,
    input wire logic [2:0]  match2Evt,
    input wire logic [2:0]  match3Evt,
    input wire logic [2:0]  cntOvfEvt,
    input wire logic [2:0]  irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // counter 1 event seen and counter 1 status read
    wire ev1 = intervalEvt[0] | match1Evt[0] | match2Evt[0] | match3Evt[0]
               | cntOvfEvt[0];
    wire rdS1 = regRead && regAddr == `OFS_CNT1_STATUS;
    // unused upper bits of every register read back zero
    property p_hiCnt; regRdData[31:16] == '0; endproperty
    a_hiCnt: assert property (p_hiCnt)
        else $error("count top bits set");
    property p_hiSt; $past(regRead) && $past(regAddr) < 8'h6c
        |-> regRdData[31:6] == '0; endproperty
    a_hiSt: assert property (p_hiSt)
        else $error("status top bits set");
    property p_hiCtl; $past(regRead) && $past(regAddr) inside {8'h6c, 8'h70,
        8'h74} |-> regRdData[31:3] == '0; endproperty
    a_hiCtl: assert property (p_hiCtl)
        else $error("control top bits");
    // read-clear of status and its interrupt
    property p_clr; rdS1 && !ev1 |=> !irqOut[0]; endproperty
    a_clr: assert property (p_clr) else $error("irq after clear");
    property p_dbl; (rdS1 && !ev1) ##1 (rdS1 && !ev1)
        |=> regRdData[4:0] == 5'h0; endproperty
    a_dbl: assert property (p_dbl)
        else $error("status not cleared");
    property p_set; (cntOvfEvt[2] && !regRead)
        ##1 (regRead && regAddr == `OFS_CNT3_STATUS) |=> regRdData[4];
    endproperty
    a_set: assert property (p_set)
        else $error("overflow flag lost");
    // enables gate the interrupt
    property p_irq; (regWrite && regAddr == `OFS_CNT1_ENABLE
        && regWrData[5:0] == 6'h3f) ##1 (intervalEvt[0] && !regWrite
        && !regRead) |=> irqOut[0]; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_en0; regWrite && regAddr == `OFS_CNT1_ENABLE
        && regWrData[5:0] == 6'h00 |-> ##2 !irqOut[0]; endproperty
    a_en0: assert property (p_en0)
        else $error("masked irq high");
    // main scenarios
    c_irq: cover property ($rose(irqOut[2]));
    c_ovf: cover property (rdS1 ##1 regRdData[5]);
    c_cnt: cover property ($past(regRead) && regRdData[15:0] > 16'h0005);
endmodule // pulse_timer_irq_monitor
bind pulse_timer_irq pulse_timer_irq_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .intervalEvt(intervalEvt),
    .match1Evt(match1Evt), .match2Evt(match2Evt), .match3Evt(match3Evt),
    .cntOvfEvt(cntOvfEvt), .irqOut(irqOut));
`default_nettype wire

// file: tb/timer_irq_and_pulse_timer_test.sv
// self-checking bench for the timer interrupt block
`default_nettype none
`include "pulse_timer_irq_consts.vh"
module timer_irq_and_pulse_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus, outputs and bookkeeping
    logic        clk = 0, rst_n = 0, regWrite = 0, regRead = 0, rdp = 0;
    logic [7:0]  regAddr = 0, a;
    logic [31:0] regWrData = 0, regRdData, ep, irqs;
    logic [14:0] ev = 0;
    logic [2:0]  pulseIn = 0, irqOut;
    logic [5:0]  msk;
    int          n_mismatch = 0, tests_run = 0, w;
    pulse_timer_irq DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .intervalEvt(ev[2:0]), .match1Evt(ev[5:3]),
        .match2Evt(ev[8:6]), .match3Evt(ev[11:9]), .cntOvfEvt(ev[14:12]),
        .pulseIn(pulseIn), .irqOut(irqOut));
    // clock
    initial forever #5 clk = ~clk;
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one cycle: op 1 read with d expected, 2 write of d, 0 idle
    task cyc(input int op, input logic [7:0] ad, input logic [31:0] d,
             input logic [14:0] e = 0);
        regRead <= op == 1;
        regWrite <= op == 2;
        regAddr <= ad;
        regWrData <= d;
        ev <= e;
        @(posedge clk);
        irqs = irqOut;
        if (rdp) chk(regRdData, ep);
        rdp = op == 1;
        ep = d;
    endtask
    task print_verdict;
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        // about 90k cycles, well past the 66k that the tests need
        #900_000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        void'($urandom(76));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        // reset values; read-only and unmapped places ignore writes
        for (a = 8'h54; a <= 8'h84; a = a + 8'h04) begin
            cyc(1, a, 0);
            if (a < 8'h60 || a > 8'h74) begin
                cyc(2, a, $urandom);
                cyc(1, a, 0);
            end
        end
        // enables and controls keep only their fields
        for (a = 8'h60; a <= 8'h74; a = a + 8'h04) begin
            w = $urandom;
            cyc(2, a, w);
            cyc(1, a, w & (a < 8'h6c ? 32'h3f : 32'h7));
            cyc(2, a, 0);
        end
        // every event of every counter under a random mask
        for (int n = 0; n < 3; n++) for (int b = 0; b < 5; b++) begin
            msk = (n + b == 0) ? 6'h3f : 6'($urandom);
            cyc(2, 8'h60 + 8'(4 * n), 32'(msk));
            cyc(0, 0, 0, 15'(1 << (3 * b + n)));
            cyc(1, 8'h54 + 8'(4 * n), 32'(1 << b));
            chk(irqs, 32'(msk[b]) << n);
            cyc(1, 8'h54 + 8'(4 * n), 0);
            chk(irqs, 0);
        end
        // random pulse widths at both levels on every timer
        for (int t = 0; t < 3; t++) for (int l = 0; l < 2; l++) begin
            w = 3 + $urandom % 40;
            pulseIn[t] <= l[0];
            cyc(2, 8'h6c + 8'(4 * t), 32'(2 * l + 1));
            repeat (3) cyc(0, 0, 0);
            pulseIn[t] <= ~l[0];
            repeat (w) cyc(0, 0, 0);
            pulseIn[t] <= l[0];
            repeat (6) cyc(0, 0, 0);
            cyc(1, 8'h78 + 8'(4 * t), w);
            cyc(2, 8'h6c + 8'(4 * t), 0);
        end
        // long pulse: timer 1 stops at overflow, timer 2 wraps
        pulseIn <= 3'h0;
        cyc(2, `OFS_PT1_CONTROL, 1);
        cyc(2, `OFS_PT2_CONTROL, 5);
        repeat (3) cyc(0, 0, 0);
        pulseIn <= 3'h3;
        repeat (65541) cyc(0, 0, 0);
        pulseIn <= 3'h0;
        repeat (6) cyc(0, 0, 0);
        cyc(1, `OFS_PT1_CONTROL, 0);
        cyc(1, `OFS_PT1_COUNT, 0);
        cyc(1, `OFS_PT2_CONTROL, 5);
        cyc(1, `OFS_PT2_COUNT, 5);
        cyc(1, `OFS_CNT1_STATUS, 32'h20);
        cyc(1, `OFS_CNT2_STATUS, 32'h20);
        // mid-run reset clears enables, controls and counts
        cyc(2, `OFS_CNT1_ENABLE, 32'h3f);
        cyc(2, `OFS_PT3_CONTROL, 7);
        rst_n <= 0;
        repeat (2) cyc(0, 0, 0);
        rst_n <= 1;
        cyc(1, `OFS_CNT1_ENABLE, 0);
        cyc(1, `OFS_PT3_CONTROL, 0);
        cyc(1, `OFS_PT2_COUNT, 0);
        cyc(1, `OFS_CNT1_STATUS, 0);
        cyc(1, `OFS_CNT1_STATUS, 0);
        cyc(0, 0, 0);
        print_verdict;
    end
endmodule // timer_irq_and_pulse_timer_test
`default_nettype wire
